// [hdl/cxtu_regs.vh]
// Constants of the exception and trap sequencing unit: APB offsets,
// status word fields, reset values, entry addresses and cause codes.
// Assumes a 32-bit APB with byte addresses and one word per register.
`ifndef CXTU_REGS_VH
`define CXTU_REGS_VH

// ----------------------------------------------------------------
// APB register offsets
// ----------------------------------------------------------------
`define CXTU_OFF_BCR        8'h00
`define CXTU_OFF_MCR        8'h04
`define CXTU_OFF_FCR        8'h08
`define CXTU_OFF_TPR        8'h0c
`define CXTU_OFF_ISR        8'h10
`define CXTU_OFF_STAT       8'h14

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CXTU_RST_BCR        32'h00000000
`define CXTU_RST_MCR        32'h00000000
`define CXTU_RST_FCR        32'h00010000
`define CXTU_RST_TPR        32'h08000000

// ----------------------------------------------------------------
// Status word fields
// ----------------------------------------------------------------
`define CXTU_SR_FP_HI       31
`define CXTU_SR_FP_LO       25
`define CXTU_SR_FL_HI       24
`define CXTU_SR_FL_LO       21
`define CXTU_SR_ILC_HI      20
`define CXTU_SR_ILC_LO      19
`define CXTU_SR_S           18
`define CXTU_SR_P           17
`define CXTU_SR_T           16
`define CXTU_SR_L           15
`define CXTU_SR_I           7
`define CXTU_SR_M           4

// ----------------------------------------------------------------
// Control bit positions and frame length codes
// ----------------------------------------------------------------
`define CXTU_FCR_XOV_DIS    16
`define CXTU_BCR_PAR_LO     28
`define CXTU_ISR_RST_LO     9
`define CXTU_FL_HW          4'h2
`define CXTU_FL_SW          4'h6

// ----------------------------------------------------------------
// Reset source codes and exception cause codes
// ----------------------------------------------------------------
`define CXTU_RSRC_PIN       2'h0
`define CXTU_RSRC_WDOG      2'h1
`define CXTU_RSRC_CLKD      2'h2
`define CXTU_CAUSE_NONE     3'h0
`define CXTU_CAUSE_RESET    3'h1
`define CXTU_CAUSE_ERROR    3'h2
`define CXTU_CAUSE_SWTRAP   3'h3
`define CXTU_CAUSE_XOV      3'h4
`define CXTU_CAUSE_PARITY   3'h5
`define CXTU_CAUSE_INTR     3'h6
`define CXTU_CAUSE_TRACE    3'h7

// ----------------------------------------------------------------
// Default entry addresses
// ----------------------------------------------------------------
`define CXTU_ENT_RESET      32'hfffffff8
`define CXTU_ENT_ERROR      32'hfffffff0
`define CXTU_ENT_XOV        32'hffffffe8
`define CXTU_ENT_PARITY     32'hffffffe0
`define CXTU_ENT_INTR       32'hffffffd8
`define CXTU_ENT_TRACE      32'hffffffd0

`endif

// [hdl/cxtu_top.v]
// Exception and trap sequencing unit with APB control registers.
// Assumes core-side inputs are on pclk; reset pin and external
// interrupt arrive asynchronously and are synchronised here.
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`include "cxtu_regs.vh"

module cxtu_top #(
    parameter [31:0] ENT_RESET  = `CXTU_ENT_RESET,
    parameter [31:0] ENT_ERROR  = `CXTU_ENT_ERROR,
    parameter [31:0] ENT_XOV    = `CXTU_ENT_XOV,
    parameter [31:0] ENT_PARITY = `CXTU_ENT_PARITY,
    parameter [31:0] ENT_INTR   = `CXTU_ENT_INTR,
    parameter [31:0] ENT_TRACE  = `CXTU_ENT_TRACE
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        reset_pin_n,
    input  wire        wdog_overrun,
    input  wire        io3_watchdog_mode,
    input  wire        io3_control_mode,
    input  wire        clkdown_reset,
    input  wire        ext_int,
    input  wire        timer_int,
    input  wire        instr_done,
    input  wire        instr_delayed_branch,
    input  wire        instr_call,
    input  wire [31:0] cur_ip,
    input  wire [31:0] cur_sr,
    input  wire        sw_trap,
    input  wire [31:0] sw_trap_entry,
    input  wire        range_err,
    input  wire        mem_req,
    input  wire        mem_post_update,
    input  wire [31:0] mem_addr_reg,
    input  wire        frame_restruct,
    input  wire [31:0] frame_stack_addr,
    input  wire [31:0] upper_stack_bound,
    input  wire        priv_op,
    input  wire        return_to_user,
    input  wire        ext_instr,
    input  wire        ext_addsub_ovf,
    input  wire        parity_err,
    input  wire [1:0]  parity_area,
    output reg         exc_busy,
    output reg         stack_we,
    output reg  [5:0]  stack_addr,
    output reg  [31:0] stack_wdata,
    output reg         trap_valid,
    output reg  [31:0] new_ip,
    output reg  [31:0] new_sr,
    output reg         pipe_flush,
    output reg         mem_go,
    output reg         addr_update,
    output reg  [31:0] bus_control_reg,
    output reg  [31:0] memory_control_reg,
    output reg  [31:0] function_control_reg,
    output reg  [31:0] timer_prescale_reg
);

localparam [1:0] ST_IDLE = 2'h0;
localparam [1:0] ST_SVPC = 2'h1;
localparam [1:0] ST_SVSR = 2'h2;
localparam [1:0] ST_DONE = 2'h3;

// ----------------------------------------------------------------
// Synchronisers
// ----------------------------------------------------------------
reg  [1:0] rpin_sync_q;
reg  [1:0] eint_sync_q;
reg        rpin_prev_q;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        rpin_sync_q <= 2'h3;
        eint_sync_q <= 2'h0;
        rpin_prev_q <= 1'b1;
    end else begin
        rpin_sync_q <= {rpin_sync_q[0], reset_pin_n};
        eint_sync_q <= {eint_sync_q[0], ext_int};
        rpin_prev_q <= rpin_sync_q[1];
    end
end

// ----------------------------------------------------------------
// Event decode
// ----------------------------------------------------------------
wire       rst_pin_ev  = rpin_sync_q[1] & ~rpin_prev_q;
wire       rst_wdog_ev = wdog_overrun & io3_watchdog_mode;
wire       rst_ev      = rst_pin_ev | rst_wdog_ev | clkdown_reset;
wire       user_state  = ~cur_sr[`CXTU_SR_S];
wire       ptr_err     = mem_req & (mem_addr_reg == 32'h00000000);
wire       frm_err     = frame_restruct &
                         (frame_stack_addr >= upper_stack_bound);
wire       prv_err     = priv_op & (user_state | return_to_user);
wire       shared_err  = range_err | ptr_err | frm_err | prv_err;
wire       xov_dis     = function_control_reg[`CXTU_FCR_XOV_DIS];
wire       xov_ev      = ext_instr & ext_addsub_ovf & ~xov_dis;
wire [3:0] par_dis     = bus_control_reg[`CXTU_BCR_PAR_LO+3:`CXTU_BCR_PAR_LO];
wire       par_ev      = parity_err & ~par_dis[parity_area];
wire       int_src     = eint_sync_q[1] | timer_int | io3_control_mode;
wire       lock        = cur_sr[`CXTU_SR_L];

// ----------------------------------------------------------------
// Pending asynchronous conditions and call shadow
// ----------------------------------------------------------------
reg        xov_pend_q;
reg        par_pend_q;
reg        call_shadow_q;
reg  [1:0] state_q;
reg  [2:0] cause_q;

wire       idle     = (state_q == ST_IDLE);
wire       boundary = idle & instr_done;
wire       xov_any  = xov_pend_q | xov_ev;
wire       par_any  = par_pend_q | par_ev;
wire       trc_ok   = cur_sr[`CXTU_SR_T] & cur_sr[`CXTU_SR_P] &
                      ~instr_delayed_branch & ~call_shadow_q & ~instr_call;

reg  [2:0] take_cause;
reg  [31:0] take_entry;

always @* begin
    take_cause = `CXTU_CAUSE_NONE;
    take_entry = ENT_RESET;
    if (rst_ev) begin
        take_cause = `CXTU_CAUSE_RESET;
        take_entry = ENT_RESET;
    end else if (boundary) begin
        if (shared_err) begin
            take_cause = `CXTU_CAUSE_ERROR;
            take_entry = ENT_ERROR;
        end else if (sw_trap) begin
            take_cause = `CXTU_CAUSE_SWTRAP;
            take_entry = sw_trap_entry;
        end else if (xov_any & ~lock) begin
            take_cause = `CXTU_CAUSE_XOV;
            take_entry = ENT_XOV;
        end else if (par_any & ~lock) begin
            take_cause = `CXTU_CAUSE_PARITY;
            take_entry = ENT_PARITY;
        end else if (int_src & ~lock) begin
            take_cause = `CXTU_CAUSE_INTR;
            take_entry = ENT_INTR;
        end else if (trc_ok) begin
            take_cause = `CXTU_CAUSE_TRACE;
            take_entry = ENT_TRACE;
        end
    end
end

wire take_any = (take_cause != `CXTU_CAUSE_NONE);

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        xov_pend_q    <= 1'b0;
        par_pend_q    <= 1'b0;
        call_shadow_q <= 1'b0;
    end else begin
        if (take_cause == `CXTU_CAUSE_XOV || xov_dis)
            xov_pend_q <= 1'b0;
        else if (xov_ev)
            xov_pend_q <= 1'b1;
        if (take_cause == `CXTU_CAUSE_PARITY)
            par_pend_q <= par_pend_q & par_ev;
        else if (par_ev)
            par_pend_q <= 1'b1;
        if (boundary)
            call_shadow_q <= instr_call;
    end
end

// ----------------------------------------------------------------
// Pointer error access suppression
// ----------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        mem_go      <= 1'b0;
        addr_update <= 1'b0;
    end else begin
        mem_go      <= mem_req & ~ptr_err;
        addr_update <= mem_req & mem_post_update;
    end
end

// ----------------------------------------------------------------
// Entry sequence
// ----------------------------------------------------------------
reg  [31:0] old_ip_q;
reg  [31:0] old_sr_q;
reg  [31:0] entry_q;
wire [3:0]  old_fl   = old_sr_q[`CXTU_SR_FL_HI:`CXTU_SR_FL_LO];
wire [6:0]  old_fp   = old_sr_q[`CXTU_SR_FP_HI:`CXTU_SR_FP_LO];
wire [4:0]  fl_eff   = (old_fl == 4'h0) ? 5'h10 : {1'b0, old_fl};
wire [6:0]  slot_pc  = old_fp + {2'h0, fl_eff};
wire [6:0]  slot_sr  = slot_pc + 7'h01;
wire        is_reset = (cause_q == `CXTU_CAUSE_RESET);

reg  [31:0] sr_d;

always @* begin
    sr_d = old_sr_q;
    sr_d[`CXTU_SR_S] = 1'b1;
    sr_d[`CXTU_SR_M] = 1'b0;
    sr_d[`CXTU_SR_T] = 1'b0;
    sr_d[`CXTU_SR_L] = 1'b1;
    if (!is_reset) begin
        sr_d[`CXTU_SR_FP_HI:`CXTU_SR_FP_LO] = slot_pc;
        sr_d[`CXTU_SR_FL_HI:`CXTU_SR_FL_LO] =
            (cause_q == `CXTU_CAUSE_SWTRAP) ? `CXTU_FL_SW : `CXTU_FL_HW;
    end
    if (cause_q == `CXTU_CAUSE_INTR)
        sr_d[`CXTU_SR_I] = 1'b1;
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        state_q     <= ST_IDLE;
        cause_q     <= `CXTU_CAUSE_NONE;
        old_ip_q    <= 32'h00000000;
        old_sr_q    <= 32'h00000000;
        entry_q     <= 32'h00000000;
        exc_busy    <= 1'b0;
        stack_we    <= 1'b0;
        stack_addr  <= 6'h00;
        stack_wdata <= 32'h00000000;
        trap_valid  <= 1'b0;
        new_ip      <= 32'h00000000;
        new_sr      <= 32'h00000000;
        pipe_flush  <= 1'b0;
    end else begin
        stack_we   <= 1'b0;
        trap_valid <= 1'b0;
        pipe_flush <= 1'b0;
        if (take_any && (idle || take_cause == `CXTU_CAUSE_RESET)) begin
            cause_q  <= take_cause;
            old_ip_q <= cur_ip;
            old_sr_q <= cur_sr;
            entry_q  <= take_entry;
            exc_busy <= 1'b1;
            state_q  <= (take_cause == `CXTU_CAUSE_RESET) ? ST_DONE : ST_SVPC;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    exc_busy <= 1'b0;
                end
                ST_SVPC: begin
                    stack_we    <= 1'b1;
                    stack_addr  <= slot_pc[5:0];
                    stack_wdata <= {old_ip_q[31:1], old_sr_q[`CXTU_SR_S]};
                    state_q     <= ST_SVSR;
                end
                ST_SVSR: begin
                    stack_we    <= 1'b1;
                    stack_addr  <= slot_sr[5:0];
                    stack_wdata <= old_sr_q;
                    state_q     <= ST_DONE;
                end
                ST_DONE: begin
                    trap_valid <= 1'b1;
                    new_ip     <= entry_q;
                    new_sr     <= sr_d;
                    pipe_flush <= is_reset;
                    exc_busy   <= 1'b0;
                    state_q    <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
end

// ----------------------------------------------------------------
// Control registers and reset source
// ----------------------------------------------------------------
reg  [1:0]  rst_src_q;
wire        apb_acc = psel & penable & pready;
wire        apb_wr  = apb_acc & pwrite;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        bus_control_reg      <= `CXTU_RST_BCR;
        memory_control_reg   <= `CXTU_RST_MCR;
        function_control_reg <= `CXTU_RST_FCR;
        timer_prescale_reg   <= `CXTU_RST_TPR;
        rst_src_q            <= `CXTU_RSRC_PIN;
    end else if (rst_ev) begin
        bus_control_reg    <= `CXTU_RST_BCR;
        memory_control_reg <= `CXTU_RST_MCR;
        if (!clkdown_reset || rst_pin_ev || rst_wdog_ev)
            function_control_reg <= `CXTU_RST_FCR;
        if (!rst_wdog_ev || rst_pin_ev)
            timer_prescale_reg <= `CXTU_RST_TPR;
        if (rst_pin_ev)
            rst_src_q <= `CXTU_RSRC_PIN;
        else if (rst_wdog_ev)
            rst_src_q <= `CXTU_RSRC_WDOG;
        else
            rst_src_q <= `CXTU_RSRC_CLKD;
    end else if (apb_wr) begin
        case (paddr)
            `CXTU_OFF_BCR: bus_control_reg      <= pwdata;
            `CXTU_OFF_MCR: memory_control_reg   <= pwdata;
            `CXTU_OFF_FCR: function_control_reg <= pwdata;
            `CXTU_OFF_TPR: timer_prescale_reg   <= pwdata;
            default: begin
            end
        endcase
    end
end

// ----------------------------------------------------------------
// APB slave
// ----------------------------------------------------------------
reg  [31:0] rdata_d;
reg         map_d;

always @* begin
    map_d   = 1'b1;
    rdata_d = 32'h00000000;
    case (paddr)
        `CXTU_OFF_BCR:  rdata_d = bus_control_reg;
        `CXTU_OFF_MCR:  rdata_d = memory_control_reg;
        `CXTU_OFF_FCR:  rdata_d = function_control_reg;
        `CXTU_OFF_TPR:  rdata_d = 32'h00000000;
        `CXTU_OFF_ISR: begin
            rdata_d[`CXTU_ISR_RST_LO+1:`CXTU_ISR_RST_LO] = rst_src_q;
            rdata_d[0] = eint_sync_q[1];
        end
        `CXTU_OFF_STAT: rdata_d = {24'h000000, cause_q, call_shadow_q,
                                   par_pend_q, xov_pend_q, state_q};
        default:        map_d = 1'b0;
    endcase
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
        prdata  <= 32'h00000000;
    end else begin
        pready  <= psel & penable & ~pready;
        pslverr <= psel & penable & ~pready & ~map_d;
        prdata  <= (psel & penable & ~pready & ~pwrite) ? rdata_d : 32'h00000000;
    end
end

endmodule

// [verif/cxtu_asserts.sv]
// Checker for the exception unit: entry flags, frame save, resets.
// Bound to cxtu_top; sees only its ports, one clock domain.
`timescale 1ns/1ns
`include "cxtu_regs.vh"
module cxtu_asserts #(
    parameter [31:0] ENT_RESET = 32'h0,
    parameter [31:0] ENT_ERROR = 32'h0
) (
    input wire logic        pclk, presetn, instr_done, exc_busy, sw_trap, range_err, priv_op,
    input wire logic        mem_req, mem_post_update, mem_go, addr_update, frame_restruct,
    input wire logic        stack_we, trap_valid, pipe_flush, wdog_overrun, io3_watchdog_mode,
    input wire logic        clkdown_reset,
    input wire logic [5:0]  stack_addr,
    input wire logic [31:0] cur_ip, cur_sr, mem_addr_reg, stack_wdata, new_ip, new_sr,
    input wire logic [31:0] function_control_reg, timer_prescale_reg
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    wire [4:0] fl_eff  = (cur_sr[24:21] == 4'h0) ? 5'h10 : {1'b0, cur_sr[24:21]};
    wire [6:0] fp_next = cur_sr[31:25] + {2'b00, fl_eff};
    wire       take    = instr_done && !exc_busy;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_pc;
        stack_we && !$past(stack_we);
    endsequence
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    chk_entry_flags: assert property (
        trap_valid |-> new_sr[18] && new_sr[15] && !new_sr[16] && !new_sr[4])
        else $error("entry flags wrong");
    chk_pc_save: assert property (
        s_pc |-> stack_addr == $past(fp_next[5:0])
        && stack_wdata == {$past(cur_ip[31:1]), $past(cur_sr[18])})
        else $error("pointer save wrong");
    chk_sr_save: assert property (
        s_pc |=> stack_we && stack_addr == $past(stack_addr) + 6'h1
        && stack_wdata == $past(cur_sr, 2))
        else $error("status save wrong");
    chk_frame_new: assert property (
        s_pc ##1 stack_we |=> trap_valid && new_sr[31:25] == $past(fp_next, 3)
        && (new_sr[24:21] == `CXTU_FL_HW || new_sr[24:21] == `CXTU_FL_SW))
        else $error("new frame wrong");
    chk_sw_len: assert property (
        take && sw_trap && !(range_err || priv_op || mem_req || frame_restruct)
        |-> ##4 trap_valid && new_sr[24:21] == `CXTU_FL_SW)
        else $error("trap frame length wrong");
    chk_err_entry: assert property (
        take && range_err |-> ##4 trap_valid && new_ip == ENT_ERROR
        && new_sr[24:21] == `CXTU_FL_HW)
        else $error("error entry wrong");
    chk_reset_flush: assert property (
        pipe_flush |-> trap_valid && new_ip == ENT_RESET)
        else $error("flush without reset entry");
    chk_ptr_access: assert property (
        mem_req && mem_addr_reg == 32'h0 |=> !mem_go && addr_update == $past(mem_post_update))
        else $error("zero address access");
    chk_wdog_keep: assert property (
        wdog_overrun && io3_watchdog_mode |=> $stable(timer_prescale_reg)
        && function_control_reg == `CXTU_RST_FCR)
        else $error("watchdog reset registers wrong");
    chk_clkd_keep: assert property (
        clkdown_reset |=> $stable(function_control_reg)
        && timer_prescale_reg == `CXTU_RST_TPR)
        else $error("clock-down reset registers wrong");
endmodule
bind cxtu_top cxtu_asserts #(.ENT_RESET(ENT_RESET), .ENT_ERROR(ENT_ERROR)) u_chk (.*);

// [verif/cxtu_top_tb.sv]
// Self-checking bench for the exception unit: APB tasks and boundary steps.
// Assumes cxtu_top with default entry addresses and one 250 MHz clock.
`timescale 1ns/1ns
`include "cxtu_regs.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module cxtu_top_tb;
    localparam logic [31:0] IP0 = 32'h00001234;
    localparam logic [31:0] SR0 = 32'h0a09001f;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        reset_pin_n = 1'b1, wdog_overrun = 1'b0, io3_watchdog_mode = 1'b0;
    logic        io3_control_mode = 1'b0, clkdown_reset = 1'b0, ext_int = 1'b0;
    logic        timer_int = 1'b0, instr_done = 1'b0, instr_delayed_branch = 1'b0;
    logic        instr_call = 1'b0, sw_trap = 1'b0, range_err = 1'b0, mem_req = 1'b0;
    logic        mem_post_update = 1'b1, frame_restruct = 1'b0, priv_op = 1'b0;
    logic        return_to_user = 1'b0, ext_instr = 1'b0, ext_addsub_ovf = 1'b0;
    logic        parity_err = 1'b0;
    logic [1:0]  parity_area = 2'h2;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, cur_ip = IP0, cur_sr = SR0, sw_trap_entry = 32'h200;
    logic [31:0] mem_addr_reg = 32'h0, frame_stack_addr = 32'h100, upper_stack_bound = 32'h100;
    logic [31:0] prdata, new_ip, new_sr, stack_wdata, bus_control_reg, memory_control_reg;
    logic [31:0] function_control_reg, timer_prescale_reg, rd, pd, sd;
    logic        pready, pslverr, exc_busy, stack_we, trap_valid, pipe_flush, mem_go;
    logic        addr_update, perr;
    logic [5:0]  stack_addr, pa, sa;
    int          n_errors = 0, comparisons = 0, k;

    cxtu_top u_cxtu_top (.*);
    always #2 pclk = ~pclk;
    always @(posedge pclk) if (stack_we === 1'b1) begin
        pa <= sa; pd <= sd; sa <= stack_addr; sd <= stack_wdata;
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task summarize;
        if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge pclk) penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin n_errors++; summarize; end
        rd = prdata; perr = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task wait_trap(input logic [31:0] exp_ip);
        int i; logic got;
        got = 1'b0;
        for (i = 0; i < 8 && !got; i++) begin @(posedge pclk); #1 got = (trap_valid === 1'b1); end
        `CHK(got, exp_ip != 32'h0)
        if (got) `CHK(new_ip, exp_ip)
    endtask
    task step(input logic [31:0] exp_ip);
        @(posedge pclk) instr_done <= 1'b1;
        @(posedge pclk) instr_done <= 1'b0;
        wait_trap(exp_ip);
    endtask
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `CXTU_OFF_BCR, 0); `CHK(rd, `CXTU_RST_BCR)
        apb(0, `CXTU_OFF_FCR, 0); `CHK(rd, `CXTU_RST_FCR)
        apb(0, 8'h18, 0); `CHK(perr, 1'b1)
        for (k = 0; k < 4; k++) begin
            @(posedge pclk) {range_err, mem_req, frame_restruct, priv_op} <= 4'b1000 >> k;
            step(`CXTU_ENT_ERROR);
            `CHK({pa, pd}, {6'd21, IP0})
            `CHK({sa, sd}, {6'd22, SR0})
            `CHK(new_sr & 32'hffe7ffff, 32'h2a44800f)
        end
        @(posedge pclk) {range_err, mem_req, frame_restruct, priv_op, sw_trap} <= 5'b00001;
        step(32'h200); `CHK(new_sr[24:21], `CXTU_FL_SW)
        @(posedge pclk) {sw_trap, range_err, timer_int} <= 3'b011;
        step(`CXTU_ENT_ERROR);
        for (k = 0; k < 3; k++) begin
            @(posedge pclk) {range_err, ext_int, timer_int, io3_control_mode} <= 4'b0100 >> k;
            repeat (3) @(posedge pclk);
            step(`CXTU_ENT_INTR); `CHK(new_sr[7], 1'b1)
        end
        @(posedge pclk) {io3_control_mode, timer_int, cur_sr} <= {2'b01, SR0 | 32'h8000};
        step(0);
        @(posedge pclk) {timer_int, parity_err} <= 2'b01;
        @(posedge pclk) parity_err <= 1'b0;
        apb(1, `CXTU_OFF_BCR, 32'hf0000000);
        step(0);
        @(posedge pclk) cur_sr <= SR0;
        step(`CXTU_ENT_PARITY);
        @(posedge pclk) parity_err <= 1'b1;
        @(posedge pclk) parity_err <= 1'b0;
        step(0);
        apb(1, `CXTU_OFF_BCR, 32'hb0000000);
        @(posedge pclk) parity_err <= 1'b1;
        @(posedge pclk) parity_err <= 1'b0;
        step(`CXTU_ENT_PARITY);
        for (k = 0; k < 3; k++) begin
            if (k == 1) apb(1, `CXTU_OFF_FCR, 0);
            @(posedge pclk) {ext_instr, ext_addsub_ovf, cur_sr} <= {2'b11, SR0 | 32'h8000};
            @(posedge pclk) {ext_instr, ext_addsub_ovf} <= 2'b00;
        end
        @(posedge pclk) cur_sr <= SR0;
        step(`CXTU_ENT_XOV);
        step(0);
        @(posedge pclk) {cur_sr, instr_delayed_branch} <= {SR0 | 32'h20000, 1'b1};
        step(0);
        @(posedge pclk) {instr_delayed_branch, instr_call} <= 2'b01;
        step(0);
        @(posedge pclk) instr_call <= 1'b0;
        step(0);
        step(`CXTU_ENT_TRACE); `CHK(new_sr[16], 1'b0)
        @(posedge pclk) cur_sr <= SR0;
        apb(1, `CXTU_OFF_TPR, 32'h00050000);
        for (k = 0; k < 2; k++) begin
            @(posedge pclk) {io3_watchdog_mode, wdog_overrun} <= {k[0], 1'b1};
            @(posedge pclk) wdog_overrun <= 1'b0;
            wait_trap(k ? `CXTU_ENT_RESET : 32'h0);
        end
        `CHK(pipe_flush, 1'b1)
        `CHK({function_control_reg, timer_prescale_reg}, {`CXTU_RST_FCR, 32'h00050000})
        apb(0, `CXTU_OFF_ISR, 0); `CHK(rd[10:9], `CXTU_RSRC_WDOG)
        apb(1, `CXTU_OFF_FCR, 0);
        @(posedge pclk) clkdown_reset <= 1'b1;
        @(posedge pclk) clkdown_reset <= 1'b0;
        wait_trap(`CXTU_ENT_RESET);
        `CHK({function_control_reg, timer_prescale_reg}, {32'h0, `CXTU_RST_TPR})
        apb(0, `CXTU_OFF_ISR, 0); `CHK(rd[10:9], `CXTU_RSRC_CLKD)
        apb(1, `CXTU_OFF_MCR, 32'h5);
        @(posedge pclk) reset_pin_n <= 1'b0;
        repeat (3) @(posedge pclk);
        reset_pin_n <= 1'b1;
        wait_trap(`CXTU_ENT_RESET);
        `CHK({memory_control_reg, function_control_reg}, {`CXTU_RST_MCR, `CXTU_RST_FCR})
        apb(0, `CXTU_OFF_ISR, 0); `CHK(rd[10:9], `CXTU_RSRC_PIN)
        summarize;
    end
endmodule
